// ---- rtl/flash_cfg_freeze_quad_ctrl.sv ----
`timescale 1ns/1ps

// ************************************************************
// Serial link: shifts command frames in, shifts read data out
// ************************************************************
module flash_serial_link
    import flash_cfg_pkg::*;
(
    // Link clock and frame.
    input wire logic sck_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    // Register copies from the core domain.
    input wire regs_s regs_i,
    // Frame to the core, read data to the pin.
    output frame_s frame_o,
    output logic so_o,
    output logic so_oe_o
);

    typedef struct packed {
        regs_s snap_meta;
        regs_s snap;
        frame_s frame;
    } link_state_s;

    link_state_s state_reg;
    link_state_s state_next;
    logic fresh_reg;
    logic so_reg;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] read_byte;
    logic read_active;
    logic [5:0] wr_idx;

    // Chip select high arms a new frame; the clock may stop between frames,
    // so frame start is marked asynchronously instead of by a clock edge.
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    assign cmd = state_reg.frame.rx[47:40];
    assign addr = state_reg.frame.rx[39:16];
    assign wr_idx = 6'(FRAME_BITS - 1) - state_reg.frame.bits[5:0];

    // Shift in on the rising edge; register copies are quasi-static levels.
    always_comb begin
        state_next = state_reg;
        state_next.snap_meta = regs_i;
        state_next.snap = state_reg.snap_meta;
        if (fresh_reg) begin
            state_next.frame.rx = '0;
            state_next.frame.rx[FRAME_BITS-1] = si_i;
            state_next.frame.bits = 7'h01;
        end else if (state_reg.frame.bits != BITS_MAX) begin
            if (state_reg.frame.bits < 7'(FRAME_BITS)) begin
                state_next.frame.rx[wr_idx] = si_i;
            end
            state_next.frame.bits = state_reg.frame.bits + 7'h01;
        end
    end

    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Readback selection, served on single-bit output in every width mode.
    always_comb begin
        read_byte = BYTE_ZERO;
        read_active = 1'b0;
        if (state_reg.frame.bits >= BITS_CMD_END && cmd == CMD_CONFIG_READ) begin
            read_byte = state_reg.snap.config_one_live;
            read_active = 1'b1;
        end else if (state_reg.frame.bits >= BITS_ADDR_END
                     && cmd == CMD_ADDRESSED_REG_READ) begin
            read_active = 1'b1;
            unique case (addr)
                ADDR_PERSISTENT_STATUS_ONE: read_byte = state_reg.snap.status_nv;
                ADDR_LIVE_STATUS_ONE: read_byte = state_reg.snap.status_live;
                ADDR_PERSISTENT_CONFIG_ONE: read_byte = state_reg.snap.config_one_nv;
                ADDR_LIVE_CONFIG_ONE: read_byte = state_reg.snap.config_one_live;
                ADDR_PERSISTENT_CONFIG_TWO: read_byte = state_reg.snap.config_two_nv;
                ADDR_LIVE_CONFIG_TWO: read_byte = state_reg.snap.config_two_live;
                default: read_byte = BYTE_ZERO;
            endcase
        end
    end

    // Data changes on the falling edge so the host samples it on the rising one.
    always_ff @(negedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_reg <= 1'b0;
        end else begin
            so_reg <= read_byte[3'h7 - state_reg.frame.bits[2:0]];
        end
    end

    assign frame_o = state_reg.frame;
    assign so_o = so_reg;
    assign so_oe_o = read_active & ~cs_n_i;

endmodule

// ************************************************************
// Configuration core on the system clock
// ************************************************************
module flash_cfg_freeze_quad_ctrl
    import flash_cfg_pkg::*;
#(
    parameter logic [23:0] OTP_AREA_FIRST = 24'h000000,
    parameter logic [23:0] OTP_AREA_LAST = 24'h0003ff,
    parameter logic FREEZE_DEFAULT = 1'b0
) (
    // System clock and reset.
    input wire logic MCLK_I,
    input wire logic NRST_I,
    // Serial bus pins.
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic SI_I,
    output logic SO_O,
    output logic SO_OE_O,
    input wire logic WP_N_I,
    output logic WP_N_O,
    output logic WP_N_OE_O,
    input wire logic DATA3_OR_RESET_N_I,
    output logic DATA3_OR_RESET_N_O,
    output logic DATA3_OR_RESET_N_OE_O,
    // Device-side controls and status.
    input wire logic SOFT_RESET_I,
    output logic OTP_PROG_GO_O,
    output logic PROG_ERR_O,
    output logic FREEZE_O,
    output logic WIDE_PATH_O,
    output logic WP_INTERNAL_N_O,
    output logic [7:0] LIVE_CONFIG_O
);

    // Reversed area bounds would make every program command miss, so refuse them.
    if (OTP_AREA_LAST < OTP_AREA_FIRST) begin
        $error("One-time area bounds reversed.");
    end

    typedef struct packed {
        logic [7:0] status_nv;
        logic [2:0] level_live;
        logic [7:0] config_one_nv;
        logic wide;
        logic freeze;
        logic [7:0] config_two_nv;
        logic [7:0] config_two_live;
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic wp_meta;
        logic wp_sync;
        logic d3_meta;
        logic d3_sync;
        logic prog_err;
        logic otp_go;
        logic [7:0] config_one_out;
    } core_state_s;

    core_state_s state_reg;
    core_state_s state_next;
    logic rst_meta_reg;
    logic rst_n_reg;
    regs_s regs;
    frame_s frame;
    logic [7:0] live_cfg;
    logic [7:0] status_live;

    // Reset release is synchronised; assertion stays asynchronous.
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Shadow bits are rebuilt from the persistent copy, so they track it
    // on every change and no write path can reach them.
    always_comb begin
        live_cfg = BYTE_ZERO;
        live_cfg[BIT_ORIGIN] = state_reg.config_one_nv[BIT_ORIGIN];
        live_cfg[BIT_SOURCE] = state_reg.config_one_nv[BIT_SOURCE];
        live_cfg[BIT_PARAM_PLACE] = state_reg.config_one_nv[BIT_PARAM_PLACE];
        live_cfg[BIT_WIDE] = state_reg.wide;
        live_cfg[BIT_FREEZE] = state_reg.freeze;
        status_live = state_reg.status_nv;
        status_live[BIT_LEVEL_HI:BIT_LEVEL_LO] = state_reg.level_live;
    end

    assign regs = '{status_nv: state_reg.status_nv, status_live: status_live,
                    config_one_nv: state_reg.config_one_nv,
                    config_one_live: state_reg.config_one_out,
                    config_two_nv: state_reg.config_two_nv,
                    config_two_live: state_reg.config_two_live};

    flash_serial_link u_link (
        .sck_i(SCK_I),
        .rst_n_i(rst_n_reg),
        .cs_n_i(CS_N_I),
        .si_i(SI_I),
        .regs_i(regs),
        .frame_o(frame),
        .so_o(SO_O),
        .so_oe_o(SO_OE_O)
    );

    // Frame decode and register updates; a frame is acted on once chip
    // select has risen, when the link fields are already stable.
    always_comb begin
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] wdat;
        logic frame_end;
        logic wp_int_n;
        logic four_proto;
        logic data3_or_reset_n;
        cmd = frame.rx[47:40];
        addr = frame.rx[39:16];
        b1 = frame.rx[39:32];
        b2 = frame.rx[31:24];
        wdat = frame.rx[15:8];
        frame_end = state_reg.cs_sync & ~state_reg.cs_prev;
        four_proto = state_reg.config_two_live[BIT_PROTOCOL_FOUR];
        wp_int_n = state_reg.wide | state_reg.wp_sync;
        data3_or_reset_n = state_reg.config_two_live[BIT_DATA3_RESET_EN] & ~state_reg.d3_sync
                    & (state_reg.cs_sync | ~state_reg.wide);
        state_next = state_reg;
        state_next.cs_meta = CS_N_I;
        state_next.cs_sync = state_reg.cs_meta;
        state_next.cs_prev = state_reg.cs_sync;
        state_next.wp_meta = WP_N_I;
        state_next.wp_sync = state_reg.wp_meta;
        state_next.d3_meta = DATA3_OR_RESET_N_I;
        state_next.d3_sync = state_reg.d3_meta;
        state_next.otp_go = 1'b0;

        if (data3_or_reset_n) begin
            // Hardware reset also releases the freeze.
            state_next.freeze = FREEZE_DEFAULT;
            state_next.wide = state_reg.config_one_nv[BIT_WIDE];
            state_next.level_live = state_reg.status_nv[BIT_LEVEL_HI:BIT_LEVEL_LO];
            state_next.config_two_live = state_reg.config_two_nv;
            state_next.prog_err = 1'b0;
        end else if (SOFT_RESET_I) begin
            // Software reset reloads everything except the freeze.
            state_next.wide = state_reg.config_one_nv[BIT_WIDE];
            state_next.level_live = state_reg.status_nv[BIT_LEVEL_HI:BIT_LEVEL_LO];
            state_next.config_two_live = state_reg.config_two_nv;
            state_next.prog_err = 1'b0;
        end
        // A frame that ends beside a software reset is still carried out, so a
        // program error raised by it survives the clear instead of being lost.
        if (frame_end && !data3_or_reset_n) begin
            if (cmd == CMD_LEGACY_REG_WRITE && frame.bits >= BITS_ONE_BYTE
                && !(state_reg.status_nv[BIT_WRITE_DISABLE] && !wp_int_n)) begin
                state_next.status_nv[BIT_WRITE_DISABLE] = b1[BIT_WRITE_DISABLE];
                if (!state_reg.freeze) begin
                    state_next.level_live = b1[BIT_LEVEL_HI:BIT_LEVEL_LO];
                    if (!state_reg.config_one_nv[BIT_SOURCE]) begin
                        state_next.status_nv[BIT_LEVEL_HI:BIT_LEVEL_LO] =
                            b1[BIT_LEVEL_HI:BIT_LEVEL_LO];
                    end
                end
                if (frame.bits >= BITS_TWO_BYTES) begin
                    if (!state_reg.freeze) begin
                        state_next.config_one_nv = state_reg.config_one_nv
                                                   | (b2 & ONE_TIME_CFG_MASK);
                    end
                    // Default written first, then copied to the live bit.
                    state_next.config_one_nv[BIT_WIDE] = b2[BIT_WIDE] | four_proto;
                    state_next.wide = b2[BIT_WIDE] | four_proto;
                    state_next.freeze = state_reg.freeze | b2[BIT_FREEZE];
                end
            end else if (cmd == CMD_ADDRESSED_REG_WRITE && frame.bits >= BITS_ADDR_DATA) begin
                unique case (addr)
                    ADDR_PERSISTENT_STATUS_ONE: begin
                        state_next.status_nv[BIT_WRITE_DISABLE] = wdat[BIT_WRITE_DISABLE];
                        if (!state_reg.freeze) begin
                            state_next.status_nv[BIT_LEVEL_HI:BIT_LEVEL_LO] =
                                wdat[BIT_LEVEL_HI:BIT_LEVEL_LO];
                        end
                    end
                    ADDR_LIVE_STATUS_ONE: begin
                        if (!state_reg.freeze) begin
                            state_next.level_live = wdat[BIT_LEVEL_HI:BIT_LEVEL_LO];
                        end
                    end
                    ADDR_PERSISTENT_CONFIG_ONE: begin
                        if (!state_reg.freeze) begin
                            state_next.config_one_nv = state_reg.config_one_nv
                                                       | (wdat & ONE_TIME_CFG_MASK);
                        end
                        state_next.config_one_nv[BIT_WIDE] = wdat[BIT_WIDE] | four_proto;
                    end
                    ADDR_LIVE_CONFIG_ONE: begin
                        // Live-only change; the persistent default is untouched.
                        state_next.wide = wdat[BIT_WIDE] | four_proto;
                        state_next.freeze = state_reg.freeze | wdat[BIT_FREEZE];
                    end
                    ADDR_PERSISTENT_CONFIG_TWO: begin
                        // A bit may leave its default once and never return.
                        state_next.config_two_nv = state_reg.config_two_nv
                            ^ ((wdat ^ state_reg.config_two_nv)
                               & ~(state_reg.config_two_nv ^ CONFIG_TWO_DEFAULT));
                        if (state_next.config_two_nv[BIT_PROTOCOL_FOUR]) begin
                            state_next.config_one_nv[BIT_WIDE] = 1'b1;
                        end
                    end
                    ADDR_LIVE_CONFIG_TWO: state_next.config_two_live = wdat;
                    default: state_next.config_two_live = state_reg.config_two_live;
                endcase
            end else if (cmd == CMD_ONE_TIME_AREA_PROGRAM && frame.bits >= BITS_ADDR_DATA
                         && addr >= OTP_AREA_FIRST && addr <= OTP_AREA_LAST) begin
                if (state_reg.freeze) begin
                    state_next.prog_err = 1'b1;
                end else begin
                    state_next.otp_go = 1'b1;
                end
            end
        end
        state_next.config_one_out = live_cfg;
    end

    // Power-on values; the live freeze comes from its persistent default.
    always_ff @(posedge MCLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= '0;
            state_reg.config_one_nv[BIT_FREEZE] <= FREEZE_DEFAULT;
            state_reg.freeze <= FREEZE_DEFAULT;
            state_reg.config_two_nv <= CONFIG_TWO_DEFAULT;
            state_reg.config_two_live <= CONFIG_TWO_DEFAULT;
            state_reg.level_live <= LEVEL_ZERO;
            state_reg.cs_meta <= 1'b1;
            state_reg.cs_sync <= 1'b1;
            state_reg.cs_prev <= 1'b1;
            state_reg.wp_meta <= 1'b1;
            state_reg.wp_sync <= 1'b1;
            state_reg.d3_meta <= 1'b1;
            state_reg.d3_sync <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Quad data transfers are not served, so pins two and three are never driven.
    assign WP_N_O = 1'b0;
    assign WP_N_OE_O = 1'b0;
    assign DATA3_OR_RESET_N_O = 1'b0;
    assign DATA3_OR_RESET_N_OE_O = 1'b0;
    assign OTP_PROG_GO_O = state_reg.otp_go;
    assign PROG_ERR_O = state_reg.prog_err;
    assign FREEZE_O = state_reg.freeze;
    assign WIDE_PATH_O = state_reg.wide;
    assign WP_INTERNAL_N_O = state_reg.wide | state_reg.wp_sync;
    assign LIVE_CONFIG_O = state_reg.config_one_out;

endmodule

// ---- rtl/flash_cfg_pkg.sv ----
// Overview of operation
// - Bits 5,3,2 mirror one-time persistent bits.
// - Mirror bits ignore every write attempt.
// - Wide bit selects four-bit data path.
// - Wide mode: pin two data, pin three dual-use (pins two and three are never driven; pin two only loses write-protect).
// - Wide mode forces internal write-protect inactive.
// - Narrow reads still work while wide set.
// - Wide bit cannot clear while protocol select set.
// - Legacy write updates default, then live wide bit.
// - Freeze locks protect levels and one-time space.
// - Frozen register writes complete silently, no error.
// - Frozen one-time program fails, sets error flag.
// - Unfrozen: protection, freeze, one-time area writable.
// - Only power or hardware reset clears freeze.
// - Power-on loads freeze from persistent default bit.
// - Freeze may set with other bits together.
// - Freeze never blocks write-disable or wide bits.
// - Config read returns live config register.
// - Second config register only via addressed commands.
// - Persistent copy seeds live second config on resets.
// - Persistent second-config bits flip once only.
// - Persistent wide default seeds live wide bit.
package flash_cfg_pkg;

    // ************************************************************
    // Command opcodes
    // ************************************************************
    localparam logic [7:0] CMD_LEGACY_REG_WRITE = 8'h01;
    localparam logic [7:0] CMD_CONFIG_READ = 8'h35;
    localparam logic [7:0] CMD_ADDRESSED_REG_READ = 8'h65;
    localparam logic [7:0] CMD_ADDRESSED_REG_WRITE = 8'h71;
    localparam logic [7:0] CMD_ONE_TIME_AREA_PROGRAM = 8'h42;

    // ************************************************************
    // Register addresses for the addressed commands
    // ************************************************************
    localparam logic [23:0] ADDR_PERSISTENT_STATUS_ONE = 24'h000000;
    localparam logic [23:0] ADDR_PERSISTENT_CONFIG_ONE = 24'h000002;
    localparam logic [23:0] ADDR_PERSISTENT_CONFIG_TWO = 24'h000003;
    localparam logic [23:0] ADDR_LIVE_STATUS_ONE = 24'h800000;
    localparam logic [23:0] ADDR_LIVE_CONFIG_ONE = 24'h800002;
    localparam logic [23:0] ADDR_LIVE_CONFIG_TWO = 24'h800003;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_WRITE_DISABLE = 7;
    localparam int BIT_LEVEL_HI = 4;
    localparam int BIT_LEVEL_LO = 2;
    localparam int BIT_ORIGIN = 5;
    localparam int BIT_SOURCE = 3;
    localparam int BIT_PARAM_PLACE = 2;
    localparam int BIT_WIDE = 1;
    localparam int BIT_FREEZE = 0;
    localparam int BIT_PROTOCOL_FOUR = 6;
    localparam int BIT_DATA3_RESET_EN = 5;
    localparam logic [7:0] ONE_TIME_CFG_MASK = 8'h2c;

    // ************************************************************
    // Reset values and frame layout
    // ************************************************************
    localparam logic [7:0] CONFIG_TWO_DEFAULT = 8'h08;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] LEVEL_ZERO = 3'h0;
    localparam int FRAME_BITS = 48;
    localparam logic [6:0] BITS_CMD_END = 7'h08;
    localparam logic [6:0] BITS_ONE_BYTE = 7'h10;
    localparam logic [6:0] BITS_TWO_BYTES = 7'h18;
    localparam logic [6:0] BITS_ADDR_END = 7'h20;
    localparam logic [6:0] BITS_ADDR_DATA = 7'h28;
    localparam logic [6:0] BITS_MAX = 7'h7f;

    // Register copies that the link reads back.
    typedef struct packed {
        logic [7:0] status_nv;
        logic [7:0] status_live;
        logic [7:0] config_one_nv;
        logic [7:0] config_one_live;
        logic [7:0] config_two_nv;
        logic [7:0] config_two_live;
    } regs_s;

    // One captured serial frame.
    typedef struct packed {
        logic [47:0] rx;
        logic [6:0] bits;
    } frame_s;

endpackage

// ---- tb/cfg_monitor.sv ----
`timescale 1ns/1ps
// ************************************************************
// Port checker for the configuration block
// ************************************************************
module cfg_monitor (
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic NRST_I,
    // Watched pins.
    input wire logic CS_N_I,
    input wire logic DATA3_OR_RESET_N_I,
    input wire logic SOFT_RESET_I,
    input wire logic SO_OE_O,
    input wire logic OTP_PROG_GO_O,
    input wire logic PROG_ERR_O,
    input wire logic FREEZE_O,
    input wire logic WIDE_PATH_O,
    input wire logic WP_INTERNAL_N_O,
    input wire logic [7:0] LIVE_CONFIG_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    // Frozen while the reset pin stays idle long enough to flush its synchronizer.
    sequence frozen_quiet_s;
        (FREEZE_O && DATA3_OR_RESET_N_I) [*4];
    endsequence
    reserved_zero_a: assert property (LIVE_CONFIG_O[7:6] == 2'h0 && !LIVE_CONFIG_O[4])
        else $error("reserved config bits not zero");
    live_mirror_a: assert property (LIVE_CONFIG_O[1:0] == $past({WIDE_PATH_O, FREEZE_O}))
        else $error("live config does not follow wide and freeze");
    wp_release_a: assert property (WIDE_PATH_O && $past(WIDE_PATH_O) |-> WP_INTERNAL_N_O)
        else $error("internal write protect active in wide mode");
    freeze_hold_a: assert property (frozen_quiet_s |=> FREEZE_O)
        else $error("freeze cleared without hardware reset");
    soft_clear_a: assert property (SOFT_RESET_I |-> ##[1:3] !PROG_ERR_O)
        else $error("program error survived soft reset");
    frozen_no_prog_a: assert property (FREEZE_O && $past(FREEZE_O) |-> !OTP_PROG_GO_O)
        else $error("one-time program started while frozen");
    prog_pulse_a: assert property (OTP_PROG_GO_O |=> !OTP_PROG_GO_O)
        else $error("program start longer than one cycle");
    err_frozen_a: assert property ($rose(PROG_ERR_O) |-> FREEZE_O)
        else $error("program error set while not frozen");
    so_select_a: assert property (SO_OE_O |-> !CS_N_I)
        else $error("serial output driven while deselected");
endmodule

bind flash_cfg_freeze_quad_ctrl cfg_monitor mon (
    .MCLK_I(MCLK_I), .NRST_I(NRST_I), .CS_N_I(CS_N_I), .DATA3_OR_RESET_N_I(DATA3_OR_RESET_N_I),
    .SOFT_RESET_I(SOFT_RESET_I), .SO_OE_O(SO_OE_O), .OTP_PROG_GO_O(OTP_PROG_GO_O),
    .PROG_ERR_O(PROG_ERR_O), .FREEZE_O(FREEZE_O), .WIDE_PATH_O(WIDE_PATH_O),
    .WP_INTERNAL_N_O(WP_INTERNAL_N_O), .LIVE_CONFIG_O(LIVE_CONFIG_O)
);

// ---- tb/spi_host_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// Serial host, mode 0; its clock stands low between frames
// ************************************************************
module spi_host_model (
    // Bus pins.
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // Sends the top n bits MSB first and keeps the last eight bits seen on the output.
    // Only single-bit commands are sent, so the wide bit need not be set first.
    task automatic xfer(input logic [47:0] f, input int n, output logic [7:0] rd);
        rd = 8'h00;
        #37;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = f[47-i];
            #80;
            sck_o = 1'b1;
            rd = {rd[6:0], so_i};
            #80;
            sck_o = 1'b0;
        end
        #80;
        cs_n_o = 1'b1;
        si_o = ~si_o; // A released line must not keep its last value.
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ************************************************************
// Configuration block bench
// ************************************************************
module tb_top;
    import flash_cfg_pkg::*;
    logic mclk, nrst_n, sck, cs_n, si, so, so_oe, wp_n, d3_n, soft_rst;
    logic go, perr, frz, wide, wpi_n;
    logic [7:0] live;
    logic [7:0] rd;
    logic [7:0] go_count = 8'h00;
    int err_total;
    int samples_checked;
    int cycles;

    // System clock at 40 MHz.
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // A released output line floats up to its pull-up level.
    wire so_line = so_oe ? so : 1'b1;

    spi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_line));

    flash_cfg_freeze_quad_ctrl dut (
        .MCLK_I(mclk), .NRST_I(nrst_n), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .SO_O(so),
        .SO_OE_O(so_oe), .WP_N_I(wp_n), .WP_N_O(), .WP_N_OE_O(), .DATA3_OR_RESET_N_I(d3_n),
        .DATA3_OR_RESET_N_O(), .DATA3_OR_RESET_N_OE_O(), .SOFT_RESET_I(soft_rst),
        .OTP_PROG_GO_O(go), .PROG_ERR_O(perr), .FREEZE_O(frz), .WIDE_PATH_O(wide),
        .WP_INTERNAL_N_O(wpi_n), .LIVE_CONFIG_O(live)
    );

    task automatic end_sim;
        $display("checked %0d, wrong %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One frame, then enough system cycles for the update to land and the gap to pass.
    task automatic cmd(input logic [47:0] f, input int n);
        host.xfer(f, n, rd);
        repeat (10) @(posedge mclk);
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        cmd({CMD_ADDRESSED_REG_WRITE, a, d, 8'h00}, 40);
    endtask
    task automatic rdr(input logic [23:0] a, input logic [7:0] exp);
        cmd({CMD_ADDRESSED_REG_READ, a, 16'h0000}, 40);
        chk(rd, exp);
    endtask
    task automatic pulse_soft;
        @(posedge mclk);
        #1 soft_rst = 1'b1;
        @(posedge mclk);
        #1 soft_rst = 1'b0;
        repeat (10) @(posedge mclk);
    endtask

    // Counts program starts and cuts a hang short; the run needs about 4800 cycles.
    always @(posedge mclk) begin
        cycles++;
        if (go === 1'b1) begin
            go_count <= go_count + 8'h01;
        end
        if (cycles == 30000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        nrst_n = 1'b0;
        wp_n = 1'b1;
        soft_rst = 1'b0;
        d3_n = 1'b1;
        repeat (6) @(posedge mclk);
        #1 nrst_n = 1'b1;
        repeat (10) @(posedge mclk);
        cmd({CMD_CONFIG_READ, 40'h0}, 16);
        chk(rd, 8'h00);
        #1 wp_n = 1'b0;
        repeat (10) @(posedge mclk);
        chk({7'h00, wpi_n}, 8'h00);
        wr(ADDR_PERSISTENT_CONFIG_ONE, 8'h04);
        chk(live, 8'h04);
        cmd({CMD_ONE_TIME_AREA_PROGRAM, 24'h000010, 8'ha5, 8'h00}, 40);
        chk(go_count, 8'h01);
        // Setting freeze and wide together; shadows and reserved bits must ignore the ones.
        wr(ADDR_LIVE_CONFIG_ONE, 8'hff);
        chk(live, 8'h07);
        chk({7'h00, wpi_n}, 8'h01);
        rdr(ADDR_LIVE_CONFIG_ONE, 8'h07);
        cmd({CMD_CONFIG_READ, 40'h0}, 16);
        chk(rd, 8'h07);
        wr(ADDR_PERSISTENT_CONFIG_ONE, 8'h2c);
        chk(live, 8'h07);
        chk({7'h00, perr}, 8'h00);
        rdr(ADDR_PERSISTENT_CONFIG_ONE, 8'h04);
        cmd({CMD_ONE_TIME_AREA_PROGRAM, 24'h000020, 8'h5a, 8'h00}, 40);
        chk({go_count[6:0], perr}, 8'h03);
        pulse_soft();
        chk({6'h00, frz, perr}, 8'h02);
        chk(live, 8'h05);
        cmd({CMD_LEGACY_REG_WRITE, 8'h00, 8'h02, 24'h000000}, 24);
        chk(live, 8'h07);
        rdr(ADDR_PERSISTENT_CONFIG_ONE, 8'h06);
        rdr(ADDR_LIVE_CONFIG_TWO, CONFIG_TWO_DEFAULT);
        wr(ADDR_PERSISTENT_CONFIG_TWO, 8'h00);
        wr(ADDR_PERSISTENT_CONFIG_TWO, 8'h08);
        rdr(ADDR_PERSISTENT_CONFIG_TWO, 8'h00);
        pulse_soft();
        rdr(ADDR_LIVE_CONFIG_TWO, 8'h00);
        // A power reset in mid-run is one way out of the frozen state.
        #1 nrst_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1 nrst_n = 1'b1;
        repeat (10) @(posedge mclk);
        chk({7'h00, frz}, 8'h00);
        // Four-wire protocol and pin reset enabled: clearing wide must be refused.
        wr(ADDR_LIVE_CONFIG_TWO, 8'h68);
        wr(ADDR_LIVE_CONFIG_ONE, 8'h01);
        chk({6'h00, frz, wide}, 8'h03);
        // Data3 pin pulled low while deselected acts as a hardware reset.
        #1 d3_n = 1'b0;
        repeat (4) @(posedge mclk);
        #1 d3_n = 1'b1;
        repeat (10) @(posedge mclk);
        chk({6'h00, frz, wide}, 8'h00);
        rdr(ADDR_LIVE_CONFIG_TWO, CONFIG_TWO_DEFAULT);
        end_sim();
    end
endmodule
